/* File: hw/dmm_consts.svh */
// constants for the data memory map and eeprom access block
// assumes inclusion by the package and the design file only
`ifndef DMM_CONSTS_SVH
`define DMM_CONSTS_SVH
`define DMM_REGFILE_TOP   12'h020
`define DMM_IO_TOP        12'h060
`define DMM_SRAM_TOP      12'h860
`define DMM_SRAM_WORDS    2048
`define DMM_EE_BYTES      1024
`define DMM_FLASH_WORDS   16384
`define DMM_DISP_MAX      6'h3f
`define DMM_PTR_X         5'h1a
`define DMM_PTR_Y         5'h1c
`define DMM_PTR_Z         5'h1e
`define DMM_IO_EE_CTRL    6'h1c
`define DMM_IO_EE_DATA    6'h1d
`define DMM_IO_EE_PTR_LO  6'h1e
`define DMM_IO_EE_PTR_HI  6'h1f
`define DMM_CTL_READ      0
`define DMM_CTL_WRITE     1
`define DMM_CTL_ARM       2
`define DMM_ARM_CYCLES    3'h4
`define DMM_RD_STALL      3'h4
`define DMM_WR_STALL      3'h2
`define DMM_SRAM_CYCLES   2
`define DMM_EE_WRITE_US   8500
`define DMM_CLK_MHZ       50
`define DMM_OFF_CMD       32'h0000_0000
`define DMM_OFF_WDATA     32'h0000_0004
`define DMM_OFF_RDATA     32'h0000_0008
`define DMM_OFF_STATUS    32'h0000_000c
`define DMM_OFF_PTR       32'h0000_0010
`define DMM_OFF_FADDR     32'h0000_0014
`define DMM_OFF_FDATA     32'h0000_0018
`define DMM_CMD_START     31
`endif

/* File: hw/dmm_pkg.sv */
// types of the data memory map block
// assumes dmm_consts.svh is on the include path
package dmm_pkg;
`include "dmm_consts.svh"
	typedef enum logic [2:0]
	{
		DMM_MODE_DIRECT = 3'h0,
		DMM_MODE_DISP   = 3'h1,
		DMM_MODE_IND    = 3'h2,
		DMM_MODE_PREDEC = 3'h3,
		DMM_MODE_POSTINC = 3'h4
	} dmm_mode_e;
	typedef enum logic [3:0]
	{
		DMM_ST_IDLE  = 4'b0001,
		DMM_ST_SRAM  = 4'b0010,
		DMM_ST_STALL = 4'b0100,
		DMM_ST_DONE  = 4'b1000
	} dmm_state_e;
	// one access command as software writes it into the command register
	typedef struct packed
	{
		logic        start;
		logic [6:0]  unused;
		logic        write;
		logic [2:0]  mode;
		logic [1:0]  ptr_sel;
		logic [5:0]  disp;
		logic [11:0] addr;
	} dmm_cmd_s;
	typedef struct packed
	{
		logic regfile;
		logic io;
		logic sram;
	} dmm_sel_s;
	typedef logic [13:0] dmm_pc_t;
endpackage

/* File: hw/dmm_top.sv */
// data memory map: register file, io window, sram, eeprom, program flash
// assumes one AHB-Lite master, single word transfers, hclk at 50 MHz
//
// Notes on behaviour
// - addresses 0..95 hit registers and io, next 2048 hit sram
// - decoded space holds 2144 locations: registers, io, then sram
// - registers, io and sram all reachable by all five addressing modes
// - direct mode reaches any location of the data space
// - displacement mode adds 0..63 to the X, Y or Z pointer
// - pre-decrement and post-increment update the pointer pair and store it
// - registers 26..31 form the X, Y and Z pointers
// - every sram access finishes within two core clocks
// - 1024 byte eeprom, separate space, byte reads and writes
// - eeprom pointer, value and control live in the io window
// - eeprom read stalls the core four clocks
// - eeprom write start stalls the core two clocks
// - eeprom write self-timed; write strobe shows it busy
// - eeprom write only through the armed sequence, else ignored
// - program flash is 16K words of 16 bits
// - program counter is 14 bits wide
// - flash split into boot and application sections
// - any flash word readable as constant data
// - strobe must follow arm within four non-idle clocks; arm clears after four non-idle clocks
// - write strobe clears itself when the write time has passed
// - read strobe loads the value register at once
// - during a write, reads and pointer changes are blocked
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "dmm_consts.svh"
module dmm_top
	import dmm_pkg::*;
#(
	parameter int unsigned EE_WRITE_CYCLES = `DMM_EE_WRITE_US * `DMM_CLK_MHZ,
	parameter logic [13:0] BOOT_START      = 14'h3800
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             core_stall,
	output dmm_sel_s         target_sel
);
	logic [7:0]  regfile [0:31];
	logic [7:0]  io_mem  [0:63];
	logic [7:0]  sram    [0:`DMM_SRAM_WORDS-1];
	logic [7:0]  eeprom  [0:`DMM_EE_BYTES-1];
	logic [15:0] flash   [0:`DMM_FLASH_WORDS-1];

	dmm_state_e  state_reg;
	dmm_cmd_s    cmd_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  rdata_reg;
	logic [11:0] eff_addr_reg;
	logic [2:0]  stall_cnt_reg;
	logic [2:0]  arm_cnt_reg;
	logic        arm_reg;
	logic        wr_strobe_reg;
	logic [31:0] ee_timer_reg;
	logic [9:0]  ee_ptr_reg;
	logic [7:0]  ee_val_reg;
	logic [1:0]  sram_cnt_reg;
	dmm_pc_t     faddr_reg;
	logic [15:0] fdata_reg;
	logic        fboot_reg;
	logic        ph_valid_reg;
	logic        ph_write_reg;
	logic [31:0] ph_addr_reg;

	// bus address phase capture; zero wait states on register access
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg  <= 32'h0000_0000;
		end
		else if (hready)
		begin
			ph_valid_reg <= hsel && htrans[1];
			ph_write_reg <= hwrite;
			ph_addr_reg  <= haddr;
		end
	end

	logic bus_wr;
	logic cmd_busy;
	assign bus_wr   = ph_valid_reg && ph_write_reg;
	assign cmd_busy = (state_reg != DMM_ST_IDLE);

	// pointer pair from the top six registers, its writeback and the address
	logic [4:0]  ptr_base;
	logic [15:0] ptr_now;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_upd;
	logic [15:0] ea_wide;
	always_comb
	begin
		ptr_base = (cmd_reg.ptr_sel == 2'h0) ? `DMM_PTR_X
			: (cmd_reg.ptr_sel == 2'h1) ? `DMM_PTR_Y : `DMM_PTR_Z;
		ptr_now  = {regfile[ptr_base + 5'h1], regfile[ptr_base]};
		ptr_dec  = ptr_now - 16'h0001;
		ptr_upd  = (cmd_reg.mode == DMM_MODE_PREDEC) ? ptr_dec : ptr_now + 16'h0001;
		case (cmd_reg.mode)
			DMM_MODE_DIRECT:  ea_wide = {4'h0, cmd_reg.addr};
			DMM_MODE_DISP:    ea_wide = ptr_now + {10'h000, cmd_reg.disp};
			DMM_MODE_PREDEC:  ea_wide = ptr_dec;
			default:          ea_wide = ptr_now;
		endcase
	end

	// decode: one select per address, none past the sram top
	dmm_sel_s sel_now;
	always_comb
	begin
		sel_now.regfile = (eff_addr_reg < `DMM_REGFILE_TOP);
		sel_now.io      = (eff_addr_reg >= `DMM_REGFILE_TOP) && (eff_addr_reg < `DMM_IO_TOP);
		sel_now.sram    = (eff_addr_reg >= `DMM_IO_TOP) && (eff_addr_reg < `DMM_SRAM_TOP);
	end

	logic [5:0]  io_idx;
	logic [10:0] sram_idx;
	assign io_idx   = 6'(eff_addr_reg - `DMM_REGFILE_TOP);
	assign sram_idx = 11'(eff_addr_reg - `DMM_IO_TOP);

	logic wr_ctrl;
	logic arm_write;
	logic start_write;
	logic start_read;
	assign wr_ctrl   = (state_reg == DMM_ST_DONE) && cmd_reg.write && sel_now.io
		&& (io_idx == `DMM_IO_EE_CTRL);
	assign arm_write = wr_ctrl && wdata_reg[`DMM_CTL_ARM] && !wdata_reg[`DMM_CTL_WRITE];
	// write strobe without a live arm is dropped silently
	assign start_write = wr_ctrl && wdata_reg[`DMM_CTL_WRITE] && arm_reg
		&& !wr_strobe_reg;
	assign start_read  = wr_ctrl && wdata_reg[`DMM_CTL_READ] && !wr_strobe_reg;

	// command sequencer: address, access, optional stall
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg     <= DMM_ST_IDLE;
			eff_addr_reg  <= 12'hfff; // selects nothing until the first command
			sram_cnt_reg  <= 2'h0;
			stall_cnt_reg <= 3'h0;
		end
		else
		begin
			case (state_reg)
				DMM_ST_IDLE:
				begin
					if (cmd_reg.start)
					begin
						eff_addr_reg <= ea_wide[11:0];
						// pointers above 12 bits fall outside every target
						if (ea_wide[15:12] != 4'h0)
							eff_addr_reg <= 12'hfff;
						sram_cnt_reg <= 2'h0;
						state_reg    <= DMM_ST_SRAM;
					end
				end
				DMM_ST_SRAM:
				begin
					sram_cnt_reg <= sram_cnt_reg + 2'h1;
					if (sram_cnt_reg == 2'(`DMM_SRAM_CYCLES - 1))
						state_reg <= DMM_ST_DONE;
				end
				DMM_ST_DONE:
				begin
					if (start_read)
					begin
						stall_cnt_reg <= `DMM_RD_STALL;
						state_reg     <= DMM_ST_STALL;
					end
					else if (start_write)
					begin
						stall_cnt_reg <= `DMM_WR_STALL;
						state_reg     <= DMM_ST_STALL;
					end
					else
						state_reg <= DMM_ST_IDLE;
				end
				DMM_ST_STALL:
				begin
					stall_cnt_reg <= stall_cnt_reg - 3'h1;
					if (stall_cnt_reg == 3'h1)
						state_reg <= DMM_ST_IDLE;
				end
				default:
					state_reg <= DMM_ST_IDLE;
			endcase
		end
	end

	// command register; start self-clears once taken
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cmd_reg <= '0;
		else if (bus_wr && ph_addr_reg == `DMM_OFF_CMD && !cmd_busy)
			cmd_reg <= dmm_cmd_s'(hwdata);
		else if (state_reg == DMM_ST_IDLE)
			cmd_reg.start <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wdata_reg <= 8'h00;
		else if (bus_wr && ph_addr_reg == `DMM_OFF_WDATA)
			wdata_reg <= hwdata[7:0];
	end

	// data access and pointer writeback; all modes reach all targets
	logic done_pulse;
	assign done_pulse = (state_reg == DMM_ST_SRAM) && (sram_cnt_reg == 2'(`DMM_SRAM_CYCLES - 1));
	always_ff @(posedge hclk)
	begin
		if (done_pulse && cmd_reg.write && sel_now.regfile)
			regfile[eff_addr_reg[4:0]] <= wdata_reg;
		if (done_pulse && cmd_reg.write && sel_now.sram)
			sram[sram_idx] <= wdata_reg;
		if (done_pulse && cmd_reg.write && sel_now.io && io_idx != `DMM_IO_EE_CTRL
			&& io_idx != `DMM_IO_EE_PTR_LO && io_idx != `DMM_IO_EE_PTR_HI
			&& io_idx != `DMM_IO_EE_DATA)
			io_mem[io_idx] <= wdata_reg;
		if (done_pulse && (cmd_reg.mode == DMM_MODE_PREDEC || cmd_reg.mode == DMM_MODE_POSTINC))
		begin
			regfile[ptr_base]        <= ptr_upd[7:0];
			regfile[ptr_base + 5'h1] <= ptr_upd[15:8];
		end
	end

	logic [7:0] io_read;
	always_comb
	begin
		case (io_idx)
			`DMM_IO_EE_CTRL:   io_read = {5'h00, arm_reg, wr_strobe_reg, 1'b0};
			`DMM_IO_EE_DATA:   io_read = ee_val_reg;
			`DMM_IO_EE_PTR_LO: io_read = ee_ptr_reg[7:0];
			`DMM_IO_EE_PTR_HI: io_read = {6'h00, ee_ptr_reg[9:8]};
			default:           io_read = io_mem[io_idx];
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata_reg <= 8'h00;
		else if (done_pulse && !cmd_reg.write)
			rdata_reg <= sel_now.regfile ? regfile[eff_addr_reg[4:0]]
				: sel_now.sram ? sram[sram_idx]
				: sel_now.io ? io_read : 8'h00;
	end

	// eeprom pointer and value registers in the io window
	logic ee_io_wr;
	assign ee_io_wr = done_pulse && cmd_reg.write && sel_now.io;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ee_ptr_reg <= 10'h000;
		else if (ee_io_wr && !wr_strobe_reg && io_idx == `DMM_IO_EE_PTR_LO)
			ee_ptr_reg[7:0] <= wdata_reg;
		else if (ee_io_wr && !wr_strobe_reg && io_idx == `DMM_IO_EE_PTR_HI)
			ee_ptr_reg[9:8] <= wdata_reg[1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ee_val_reg <= 8'h00;
		else if (start_read)
			ee_val_reg <= eeprom[ee_ptr_reg];
		else if (ee_io_wr && io_idx == `DMM_IO_EE_DATA)
			ee_val_reg <= wdata_reg;
	end

	// arm window ticks only while an access runs; bus gaps are no core cycles
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			arm_reg     <= 1'b0;
			arm_cnt_reg <= 3'h0;
		end
		else if (arm_write)
		begin
			arm_reg     <= 1'b1;
			arm_cnt_reg <= `DMM_ARM_CYCLES;
		end
		else if (arm_reg && state_reg != DMM_ST_IDLE)
		begin
			arm_cnt_reg <= arm_cnt_reg - 3'h1;
			if (arm_cnt_reg == 3'h1 || start_write)
				arm_reg <= 1'b0;
		end
	end

	// self-timed write; strobe reads high while busy
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_strobe_reg <= 1'b0;
			ee_timer_reg  <= 32'h0000_0000;
		end
		else if (start_write)
		begin
			wr_strobe_reg <= 1'b1;
			ee_timer_reg  <= EE_WRITE_CYCLES;
		end
		else if (wr_strobe_reg)
		begin
			ee_timer_reg <= ee_timer_reg - 32'h0000_0001;
			if (ee_timer_reg == 32'h0000_0001)
				wr_strobe_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk)
	begin
		if (start_write)
			eeprom[ee_ptr_reg] <= ee_val_reg;
	end

	// program flash: word load from bus, constant read at any address
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			faddr_reg <= 14'h0000;
			fdata_reg <= 16'h0000;
			fboot_reg <= 1'b0;
		end
		else
		begin
			if (bus_wr && ph_addr_reg == `DMM_OFF_FADDR)
				faddr_reg <= hwdata[13:0];
			fdata_reg <= flash[faddr_reg];
			fboot_reg <= (faddr_reg >= BOOT_START);
		end
	end

	always_ff @(posedge hclk)
	begin
		if (bus_wr && ph_addr_reg == `DMM_OFF_FDATA)
			flash[faddr_reg] <= hwdata[15:0];
	end

	// bus read mux, registered with zero wait states
	logic [31:0] rd_next;
	always_comb
	begin
		case (haddr)
			`DMM_OFF_CMD:    rd_next = cmd_reg;
			`DMM_OFF_WDATA:  rd_next = {24'h000000, wdata_reg};
			`DMM_OFF_RDATA:  rd_next = {24'h000000, rdata_reg};
			`DMM_OFF_STATUS: rd_next = {24'h000000, cmd_busy, state_reg[1], arm_reg,
				wr_strobe_reg, 1'b0, sel_now.sram, sel_now.io, sel_now.regfile};
			`DMM_OFF_PTR:    rd_next = {22'h000000, ee_ptr_reg};
			`DMM_OFF_FADDR:  rd_next = {18'h00000, faddr_reg};
			`DMM_OFF_FDATA:  rd_next = {15'h0000, fboot_reg, fdata_reg};
			default:         rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			core_stall <= 1'b0;
			target_sel <= '0;
		end
		else
		begin
			if (hready && hsel && htrans[1] && !hwrite)
				hrdata <= rd_next;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			core_stall <= (state_reg == DMM_ST_STALL);
			target_sel <= sel_now;
		end
	end
endmodule

/* File: test/dmm_top_properties.sv */
// port checker for dmm_top
// assumes one clock hclk and async active-low hresetn
`timescale 1ns/10ps
module dmm_top_properties
	import dmm_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        core_stall,
	input wire dmm_sel_s    target_sel
);
	logic [3:0] stall_run;
	logic [3:0] since_cmd;
	logic       rd_take;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			stall_run <= 4'h0;
		else
			stall_run <= core_stall ? stall_run + 4'h1 : 4'h0;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rd_take <= 1'b0;
		else
			rd_take <= hsel && hready && htrans[1] && !hwrite;
	// saturates so a quiet bus never wraps back into range
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			since_cmd <= 4'hf;
		else if (hsel && hready && htrans[1] && hwrite && haddr == 32'h0)
			since_cmd <= 4'h0;
		else if (since_cmd != 4'hf)
			since_cmd <= since_cmd + 4'h1;
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_zero_wait;
		hreadyout == 1'b1;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("wait state");
	property p_one_target;
		$onehot0(target_sel);
	endproperty
	a_one_target: assert property (p_one_target) else $error("two targets");
	property p_stall_shape;
		$rose(core_stall) |-> core_stall ##1 core_stall ##[1:3] !core_stall;
	endproperty
	a_stall_shape: assert property (p_stall_shape) else $error("stall shape");
	property p_stall_len;
		$fell(core_stall) |-> stall_run == 4'h2 || stall_run == 4'h4;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length");
	property p_rdata_hold;
		$changed(hrdata) |-> rd_take;
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
	property p_stall_io;
		$rose(core_stall) |-> target_sel.io;
	endproperty
	a_stall_io: assert property (p_stall_io) else $error("stall not io");
	property p_sel_cause;
		$changed(target_sel) |-> since_cmd <= 4'h8;
	endproperty
	a_sel_cause: assert property (p_sel_cause) else $error("select moved");
endmodule
bind dmm_top dmm_top_properties dmm_top_properties_inst
(
	.hclk      (hclk),
	.hresetn   (hresetn),
	.hsel      (hsel),
	.haddr     (haddr),
	.htrans    (htrans),
	.hwrite    (hwrite),
	.hsize     (hsize),
	.hready    (hready),
	.hwdata    (hwdata),
	.hrdata    (hrdata),
	.hreadyout (hreadyout),
	.hresp     (hresp),
	.core_stall(core_stall),
	.target_sel(target_sel)
);

/* File: test/dmm_cpu_model.sv */
// core side model: single-word AHB-Lite master
// assumes hready is the slave's hreadyout looped back
`timescale 1ns/10ps
module dmm_cpu_model
(
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end
	// released lines flip so stale values never pass for valid
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		haddr <= ~a;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		hwdata <= ~d;
	endtask
endmodule

/* File: test/data_memory_map_access_bench.sv */
// self-checking bench for dmm_top driven through dmm_cpu_model
// assumes dmm_pkg compiled first and the checker bound
`timescale 1ns/10ps
module data_memory_map_access_bench;
	import dmm_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        core_stall;
	dmm_sel_s    target_sel;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          n_stall = 0;
	int          i;
	logic [31:0] seed = 32'h24;
	logic [11:0] corner [5] = '{12'h000, 12'h01f, 12'h03d, 12'h060, 12'h85f};
	logic [31:0] d;
	logic [31:0] r;
	logic [31:0] st;
	logic [11:0] a;
	logic [11:0] base;
	logic [13:0] fa;
	logic [5:0]  dsp;
	logic [1:0]  p;
	logic [9:0]  ep;
	logic [7:0]  v;
	int          st0;
	initial
	begin
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (core_stall === 1'b1)
			n_stall <= n_stall + 1;
	dmm_top #(.EE_WRITE_CYCLES(60)) dmm_top_inst
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hreadyout),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.core_stall(core_stall),
		.target_sel(target_sel)
	);
	dmm_cpu_model dmm_cpu_model_inst
	(
		.hclk  (hclk),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hsel  (hsel),
		.haddr (haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize (hsize),
		.hwdata(hwdata)
	);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] sel_of(input logic [11:0] ad);
		dmm_sel_s s;
		s.regfile = ad < 12'h20;
		s.io = ad >= 12'h20 && ad < 12'h60;
		s.sram = ad >= 12'h60 && ad < 12'h860;
		return {29'h0, s};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bw(input logic [31:0] ad, input logic [31:0] dt);
		logic [31:0] x;
		dmm_cpu_model_inst.xfer(1'b1, ad, dt, x);
	endtask
	task automatic br(input logic [31:0] ad, output logic [31:0] dt);
		dmm_cpu_model_inst.xfer(1'b0, ad, 32'h0, dt);
	endtask
	// one data access via the command register, then polls until idle
	task automatic acc(input logic w, input logic [2:0] m, input logic [1:0] ps,
		input logic [5:0] ds, input logic [11:0] ad, input logic [31:0] dt,
		output logic [31:0] rd);
		dmm_cmd_s c;
		logic [31:0] s;
		c = '0;
		c.start = 1'b1;
		c.write = w;
		c.mode = m;
		c.ptr_sel = ps;
		c.disp = ds;
		c.addr = ad;
		bw(32'h4, dt);
		bw(32'h0, c);
		for (int k = 0; k < 40; k++)
		begin
			br(32'hc, s);
			if (s[7] == 1'b0)
				break;
		end
		rd = 32'h0;
		if (!w)
			br(32'h8, rd);
	endtask
	task automatic dw(input logic [11:0] ad, input logic [31:0] dt);
		logic [31:0] x;
		acc(1'b1, 3'h0, 2'h0, 6'h0, ad, dt, x);
	endtask
	task automatic dr(input logic [11:0] ad, output logic [31:0] dt);
		acc(1'b0, 3'h0, 2'h0, 6'h0, ad, 32'h0, dt);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge hclk);
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		hresetn = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("stall", 32'h0, {31'h0, core_stall});
		chk("sel", 32'h0, {29'h0, target_sel});
		for (i = 0; i < 20; i++)
		begin
			a = i < 5 ? corner[i] : 12'(xs() & 1 ? xs() % 32'h20 : 32'h60 + xs() % 32'h800);
			d = xs() & 32'hff;
			dw(a, d);
			dr(a, r);
			chk("data", d, r);
			chk("sel", sel_of(a), {29'h0, target_sel});
		end
		for (i = 0; i < 2; i++)
		begin
			dr(i ? 12'hfff : 12'h860, r);
			chk("sel_top", 32'h0, {29'h0, target_sel});
		end
		// modes 1..4 on pointers Y, X, Y, Z; displacement at its top value
		for (i = 1; i < 5; i++)
		begin
			p = i == 1 ? 2'd1 : 2'(i - 2);
			base = 12'h100 + 12'(xs() % 32'h400);
			dsp = i == 1 ? 6'h3f : 6'h0;
			d = xs() & 32'hff;
			dw(12'h1a + 12'(2 * p), {24'h0, base[7:0]});
			dw(12'h1b + 12'(2 * p), {28'h0, base[11:8]});
			acc(1'b1, 3'(i), p, dsp, 12'h0, d, r);
			dr(base + 12'(dsp) - 12'(i == 3), r);
			chk("ind_data", d, r);
			dr(12'h1a + 12'(2 * p), st);
			dr(12'h1b + 12'(2 * p), r);
			chk("pointer", {20'h0, base + 12'(i == 4) - 12'(i == 3)},
				{16'h0, r[7:0], st[7:0]});
		end
		ep = 10'(xs());
		v = 8'(xs());
		dw(12'h3e, {24'h0, ep[7:0]});
		dw(12'h3f, {30'h0, ep[9:8]});
		dw(12'h3d, {24'h0, v});
		// armed sequence: arm with strobe low, then the strobe straight after
		st0 = n_stall;
		dw(12'h3c, 32'h4);
		dw(12'h3c, 32'h2);
		chk("write_stall", 32'd2, n_stall - st0);
		br(32'hc, st);
		chk("write_busy", 32'h1, {30'h0, st[5:4]});
		dw(12'h3e, {24'h0, ~ep[7:0]});
		br(32'h10, r);
		chk("ptr_hold", {22'h0, ep}, r);
		st0 = n_stall;
		dw(12'h3c, 32'h1);
		chk("busy_read", 32'h0, n_stall - st0);
		for (i = 0; i < 40; i++)
		begin
			br(32'hc, st);
			if (st[4] == 1'b0)
				break;
		end
		chk("write_done", 32'h0, {31'h0, st[4]});
		st0 = n_stall;
		dw(12'h3c, 32'h1);
		chk("read_stall", 32'd4, n_stall - st0);
		dr(12'h3d, r);
		chk("ee_data", {24'h0, v}, r);
		// unarmed strobe, then an arm that one other access lets lapse
		dw(12'h3d, {24'h0, ~v});
		st0 = n_stall;
		dw(12'h3c, 32'h2);
		br(32'hc, st);
		chk("unarmed", 32'h0, {31'h0, st[4]});
		chk("unarmed_stall", 32'h0, n_stall - st0);
		dw(12'h3c, 32'h4);
		dr(12'h000, r);
		dw(12'h3c, 32'h2);
		br(32'hc, st);
		chk("arm", 32'h0, {30'h0, st[5:4]});
		dw(12'h3c, 32'h1);
		dr(12'h3d, r);
		chk("ee_kept", {24'h0, v}, r);
		for (i = 0; i < 2; i++)
		begin
			fa = i ? 14'h3fff : 14'(xs() % 32'h3800);
			d = xs() & 32'hffff;
			bw(32'h14, {18'h0, fa});
			bw(32'h18, d);
			br(32'h18, r);
			chk("flash", {15'h0, fa >= 14'h3800, d[15:0]}, r);
		end
		br(32'h1c, r);
		chk("unmapped", 32'h0, r);
		end_of_test();
	end
endmodule
